//--- sim/ofc_flash_model.sv
// Purpose: behavioural flash device, extended SPI only
// Assumes: host makes sck, sel_n active low
// Notes: reads other than 27h, 70h and 5Ah return opcode xor byte index
`timescale 1ns/1ps
module ofc_flash_model #(
   parameter logic [63:0] PWD = 64'h0,
   parameter realtime TDESEL_NS = 50.0
) (
   // link
   input wire logic sel_n,
   input wire logic sck,
   input wire logic [7:0] io_lines_out,
   input wire logic [7:0] io_lines_oe_n,
   output logic [7:0] io_lines_in,
   // observation
   output logic [15:0] last_bits,
   output logic [7:0] wbyte,
   output logic four,
   output logic reset_ok,
   output logic [3:0] nflag
);
   // ****
   // command decode
   // ****
   int nb, dstart, j;
   logic [7:0] op, dbyte;
   logic rst_en, flag_busy;
   realtime t_up, t_gap;
   function automatic int alen(input logic [7:0] o);
      case (o)
         8'he2, 8'he3, 8'he0: alen = 4;
         8'he8, 8'he5: alen = four ? 4 : 3;
         8'h5a: alen = 3;
         default: alen = 0;
      endcase
   endfunction
   initial begin
      io_lines_in = 8'h00;
      {last_bits, wbyte, four, reset_ok, nflag, rst_en, flag_busy, op} = '0;
      {nb, dstart} = '0;
      t_up = 0.0;
      t_gap = 0.0;
   end
   always @(negedge sel_n) begin
      nb = 0;
      dstart = 1000;
      t_gap = $realtime - t_up;
   end
   always @(posedge sck) if (!sel_n) begin
      if (nb < 8) op = {op[6:0], io_lines_out[0]};
      else if (op == 8'he5 && nb >= 8 + 8 * alen(op) && nb < 16 + 8 * alen(op)) wbyte = {wbyte[6:0], io_lines_out[0]};
      nb = nb + 1;
      if (nb == 8 && op inside {8'he8, 8'he2, 8'ha7, 8'he0, 8'h27, 8'h5a, 8'h70, 8'hcd, 8'h9e, 8'h9f}) begin
         dstart = 8 + 8 * alen(op) + (op == 8'h5a ? 8 : 0) + (op == 8'hcd ? 18 : 0);
      end
   end
   always @(negedge sck) if (!sel_n) begin
      if (nb >= dstart) begin
         j = nb - dstart;
         if (op == 8'h27) dbyte = PWD[8 * ((j / 8) % 8) +: 8];
         else if (op == 8'h70) dbyte = flag_busy ? 8'h00 : 8'h80;
         else if (op == 8'h5a) dbyte = 8'(j / 8);
         else dbyte = op ^ 8'(j / 8);
         io_lines_in = {8{dbyte[7 - j % 8]}};
      end else io_lines_in = ~io_lines_in;
   end
   always @(posedge sel_n) begin
      t_up = $realtime;
      io_lines_in = ~io_lines_in;
      last_bits = 16'(nb);
      if (nb == 8 && op == 8'hb7) four = 1'b1;
      if (nb == 8 && op == 8'he9) four = 1'b0;
      if (nb == 8 && op == 8'h99 && rst_en && t_gap >= TDESEL_NS) begin
         four = 1'b0;
         flag_busy = 1'b1;
         reset_ok = 1'b1;
         nflag = 4'h0;
      end
      if (op == 8'h70 && nb > 8) begin
         nflag = nflag + 4'h1;
         flag_busy = 1'b0;
      end
      rst_en = (op == 8'h66 && nb == 8);
   end
endmodule

//--- sim/ofc_host_monitor.sv
// Purpose: protocol checks on the host controller ports
// Assumes: one pclk domain
// Notes: bound into ofc_host
`timescale 1ns/1ps
module ofc_host_monitor #(
   parameter int SCK_HALF = 4,
   parameter int DESEL_CYC = 7
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // link
   input wire logic sel_n,
   input wire logic sck,
   input wire logic [7:0] io_lines_out,
   input wire logic [7:0] io_lines_oe_n,
   input wire logic [7:0] io_lines_in
);
   // ****
   // helpers
   // ****
   logic [7:0] gap_r, rise_r, op_r;
   logic [15:0] hi_r;
   logic sck_q_r, oct_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_r <= 8'hff;
         rise_r <= 8'h00;
         op_r <= 8'h00;
         hi_r <= 16'h0000;
         sck_q_r <= 1'b0;
         oct_r <= 1'b0;
      end else begin
         gap_r <= !sel_n ? 8'h00 : (gap_r == 8'hff ? gap_r : gap_r + 8'h01);
         hi_r <= sck ? hi_r + 16'h0001 : 16'h0000;
         sck_q_r <= sck;
         rise_r <= sel_n ? 8'h00 : rise_r + {7'h00, sck & !sck_q_r};
         if (psel && penable && pwrite && paddr == 8'h04) oct_r <= pwdata[0];
         if (psel && penable && pwrite && paddr == 8'h00) op_r <= pwdata[8] ? pwdata[7:0] : 8'h00;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence apb_acc;
      psel && penable;
   endsequence
   sequence ctrl_go;
      psel && penable && pwrite && paddr == 8'h00 && pwdata[8] && !pwdata[9];
   endsequence
   ready_now_a: assert property (apb_acc |-> pready) else $error("pready low in access");
   ready_idle_a: assert property (!(psel && penable) |-> !pready) else $error("pready outside access");
   map_err_a: assert property (apb_acc ##0 (paddr > 8'h1c || paddr[1:0] != 2'b00) |-> pslverr)
      else $error("no error on unmapped address");
   map_ok_a: assert property (apb_acc ##0 (paddr <= 8'h1c && paddr[1:0] == 2'b00) |-> !pslverr)
      else $error("error on mapped address");
   desel_gap_a: assert property ($fell(sel_n) |-> gap_r >= DESEL_CYC) else $error("deselect too short");
   link_idle_a: assert property (sel_n && $past(sel_n) |-> !sck && io_lines_oe_n == 8'hff)
      else $error("link not idle while deselected");
   sck_half_a: assert property ($fell(sck) |-> hi_r == SCK_HALF) else $error("sck high phase wrong");
   bare_len_a: assert property ($rose(sel_n) && !oct_r &&
      op_r inside {8'hb7, 8'he9, 8'hb9, 8'hab, 8'he4, 8'ha6} |-> rise_r == 8'd8) else $error("bare command length wrong");
   oct_refuse_a: assert property (ctrl_go ##0 (oct_r && pwdata[7:0] inside {8'hb7, 8'he9}) |=> sel_n [*8])
      else $error("address mode command sent in octal");
endmodule

bind ofc_host ofc_host_monitor #(.SCK_HALF(SCK_HALF), .DESEL_CYC(DESEL_CYC)) u_ofc_host_monitor (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sel_n(sel_n), .sck(sck),
   .io_lines_out(io_lines_out), .io_lines_oe_n(io_lines_oe_n), .io_lines_in(io_lines_in));

//--- sim/testbench.sv
// Purpose: self-checking bench for ofc_host
// Assumes: extended SPI traffic, default timing
// Notes: APB tasks drive all requests
`timescale 1ns/1ps
module testbench;
   localparam logic [63:0] PW = 64'hf1e2d3c4b5a69788;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sel_n, sck, ev, m_four, m_rst;
   logic [7:0] paddr, io_o, io_oe_n, io_i, m_wbyte;
   logic [31:0] pwdata, prdata, rv;
   logic [31:0] tbl [18];
   logic [15:0] m_bits;
   logic [3:0] m_nflag;
   int err_count, n_compared;
   ofc_host u_ofc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sel_n(sel_n),
      .sck(sck), .io_lines_out(io_o), .io_lines_oe_n(io_oe_n), .io_lines_in(io_i));
   ofc_flash_model #(.PWD(PW)) u_ofc_flash_model (.sel_n(sel_n), .sck(sck), .io_lines_out(io_o),
      .io_lines_oe_n(io_oe_n), .io_lines_in(io_i), .last_bits(m_bits), .wbyte(m_wbyte), .four(m_four),
      .reset_ok(m_rst), .nflag(m_nflag));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // ****
   // tasks
   // ****
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         err_count++;
         test_done();
      end
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rv);
   endtask
   task automatic run(input logic [31:0] ctrl);
      int n;
      apb(1'b1, 8'h00, ctrl);
      n = 0;
      do begin
         apb(1'b0, 8'h14, 32'h0);
         n++;
      end while (rv[0] !== 1'b0 && n < 500);
      if (n >= 500) begin
         err_count++;
         test_done();
      end
   endtask
   // ****
   // sequence
   // ****
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, err_count, n_compared} = '0;
      tbl = '{32'hb9082000, 32'hab080000, 32'he82801e8, 32'he5280000, 32'hb7081000, 32'he83011e8,
         32'he5301000, 32'h5a301100, 32'he9080000, 32'he23001e2, 32'he3280000, 32'he4080000,
         32'ha6080000, 32'ha71001a7, 32'he03001e0, 32'h70100180, 32'hcd2201cd, 32'h9f10019f};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("cfg", 8'h04, 32'h00001000);
      rdchk("rlen", 8'h10, 32'h1);
      rdchk("status", 8'h14, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, ev});
      chk("unmapped data", 32'h0, rv);
      apb(1'b1, 8'h05, 32'h0);
      chk("unaligned err", 32'h1, {31'h0, ev});
      apb(1'b1, 8'h0c, 32'h5c);
      for (int i = 0; i < 18; i++) begin
         run({23'h0, 1'b1, tbl[i][31:24]});
         chk("status", {26'h0, tbl[i][13:12], 3'b010}, rv);
         chk("bits", {24'h0, tbl[i][23:16]}, {16'h0, m_bits});
         if (tbl[i][8]) begin
            apb(1'b0, 8'h1c, 32'h0);
            chk("data", {24'h0, tbl[i][7:0]}, {24'h0, rv[31:24]});
         end
      end
      chk("wbyte", 32'h5c, {24'h0, m_wbyte});
      apb(1'b1, 8'h10, 32'ha);
      run(32'h127);
      chk("pw bits", 32'd88, {16'h0, m_bits});
      rdchk("pw lo", 8'h18, PW[47:16]);
      rdchk("pw hi", 8'h1c, {PW[15:0], PW[63:48]});
      apb(1'b1, 8'h10, 32'h1);
      run(32'h1b7);
      run(32'h200);
      chk("reset status", 32'h20, rv & 32'h38);
      chk("reset taken", 32'h1, {31'h0, m_rst});
      chk("four cleared", 32'h0, {31'h0, m_four});
      chk("flag reads", 32'h2, {28'h0, m_nflag});
      apb(1'b1, 8'h04, 32'h1001);
      run(32'h1b7);
      chk("octal refused", 32'h6, rv & 32'h7);
      apb(1'b1, 8'h14, 32'h4);
      apb(1'b0, 8'h14, 32'h0);
      chk("err cleared", 32'h0, rv & 32'h4);
      test_done();
   end
endmodule

//--- src/ofc_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts of the flash command controller
// Assumes: included by its bare name
// Notes: definitions only
`ifndef OFC_CFG_SVH
`define OFC_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define OFC_OFF_CTRL 8'h00
`define OFC_OFF_CFG 8'h04
`define OFC_OFF_ADDR 8'h08
`define OFC_OFF_WDATA 8'h0c
`define OFC_OFF_RLEN 8'h10
`define OFC_OFF_STATUS 8'h14
`define OFC_OFF_RDLO 8'h18
`define OFC_OFF_RDHI 8'h1c

// ****************************************
// field positions
// ****************************************
`define OFC_CTRL_START 8
`define OFC_CTRL_SRST 9
`define OFC_CFG_OCTAL 0
`define OFC_CFG_DCFG_LO 8
`define OFC_ST_BUSY 0
`define OFC_ST_DONE 1
`define OFC_ST_ERR 2
`define OFC_ST_FOUR 3
`define OFC_ST_DPD 4
`define OFC_ST_RSTDONE 5

// ****************************************
// reset values
// ****************************************
`define OFC_DCFG_RST 5'h10
`define OFC_RLEN_RST 8'h01
`define OFC_FOUR_RST 1'b0

// ****************************************
// opcodes
// ****************************************
`define OFC_OP_EN4B 8'hb7
`define OFC_OP_EX4B 8'he9
`define OFC_OP_DPD 8'hb9
`define OFC_OP_RDPD 8'hab
`define OFC_OP_RDVLB 8'he8
`define OFC_OP_WRVLB 8'he5
`define OFC_OP_RDNVLB 8'he2
`define OFC_OP_WRNVLB 8'he3
`define OFC_OP_ERNVLB 8'he4
`define OFC_OP_RDFRZ 8'ha7
`define OFC_OP_WRFRZ 8'ha6
`define OFC_OP_RD4VLB 8'he0
`define OFC_OP_RDPWD 8'h27
`define OFC_OP_TRAIN 8'hcd
`define OFC_OP_DISC 8'h5a
`define OFC_OP_ID0 8'h9e
`define OFC_OP_ID1 8'h9f
`define OFC_OP_RSTEN 8'h66
`define OFC_OP_RSTMEM 8'h99
`define OFC_OP_RDFLAG 8'h70

// ****************************************
// timing
// ****************************************
`define OFC_PCLK_NS 8
`define OFC_SCK_HALF 4
`define OFC_DESEL_NS 50
`define OFC_DESEL_CYC ((`OFC_DESEL_NS + `OFC_PCLK_NS - 1) / `OFC_PCLK_NS)
`define OFC_OCT_DUMMY 6'd8
`define OFC_DISC_DUMMY 6'd8
`define OFC_TRAIN_EXTRA 6'd2

`endif

//--- src/ofc_host.sv
// Purpose: host controller issuing extension commands to an octal/serial flash
// Assumes: APB slave for software, host makes the link clock
// Notes: extended SPI runs 1-1-1 on io line 0 out, io line 1 in; octal DDR runs 8-8-8
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "ofc_cfg.svh"

// Operation
// - B7h enters, E9h leaves 4-byte mode; extended SPI only, no address or dummy.
// - B9h enters deep power-down, ABh leaves; no address, dummy or data.
// - E8h takes 3/4-byte address, reads volatile lock; 8 dummies in octal only.
// - E5h takes 3/4-byte address plus exactly one data byte, no dummies.
// - E2h always takes 4-byte address, reads nonvolatile lock; octal has 8 dummies.
// - E3h takes 4-byte address, no data, sets nonvolatile lock bit.
// - E4h clears nonvolatile lock bits, no address and no data.
// - A7h reads freeze bit with 8 octal dummies; A6h sets it, bare.
// - E0h always takes 4-byte address, reads volatile lock; 8 octal dummies.
// - variable-address commands take 4 bytes if 4-byte mode or octal, else 3.
// - reset is 66h then 99h in separate selections, then deselect.
// - keep deselect time between reset-enable and reset-memory commands.
// - reset complete only when flag status read shows bit 7 set.
// - discovery read takes address then eight dummy clocks, returns table data.
// - 70h returns flag status, no address, 8 dummies in octal.
module ofc_host #(
   parameter int SCK_HALF = `OFC_SCK_HALF,
   parameter int DESEL_CYC = `OFC_DESEL_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // flash link
   output logic sel_n,
   output logic sck,
   output logic [7:0] io_lines_out,
   output logic [7:0] io_lines_oe_n,
   input wire logic [7:0] io_lines_in
);

   localparam ofc_pkg::ofc_st_t ST_RST = '{state: ofc_pkg::ST_IDLE, sel_n: 1'b1, io_oe_n: 8'hff,
                                          dcfg: `OFC_DCFG_RST, rlen: `OFC_RLEN_RST, four: `OFC_FOUR_RST,
                                          default: '0};

   ofc_pkg::ofc_st_t s_r;
   ofc_pkg::ofc_st_t s_nxt;
   logic run;
   logic tick;
   logic rise;
   logic acc_wr;

   // ****************************************
   // command table
   // ****************************************
   function automatic ofc_pkg::ofc_cmd_t cmd_info(input logic [7:0] op, input logic octal,
                                                   input logic four, input logic [4:0] dcfg);
      ofc_pkg::ofc_cmd_t c;
      logic [2:0] var_len;
      logic [5:0] oct_d;
      c = '0;
      var_len = (four || octal) ? 3'd4 : 3'd3;
      oct_d = octal ? `OFC_OCT_DUMMY : 6'd0;
      c.ok = 1'b1;
      case (op)
         `OFC_OP_EN4B, `OFC_OP_EX4B: c.ok = ~octal;
         `OFC_OP_DPD, `OFC_OP_RDPD: c.ok = 1'b1;
         `OFC_OP_RDVLB: begin
            c.alen = var_len;
            c.dummy = oct_d;
            c.rd = 1'b1;
         end
         `OFC_OP_WRVLB: begin
            c.alen = var_len;
            c.wr = 1'b1;
         end
         `OFC_OP_RDNVLB, `OFC_OP_RD4VLB: begin
            c.alen = 3'd4;
            c.dummy = oct_d;
            c.rd = 1'b1;
         end
         `OFC_OP_WRNVLB: c.alen = 3'd4;
         `OFC_OP_ERNVLB, `OFC_OP_WRFRZ: c.ok = 1'b1;
         `OFC_OP_RDFRZ, `OFC_OP_RDPWD, `OFC_OP_RDFLAG: begin
            c.dummy = oct_d;
            c.rd = 1'b1;
         end
         `OFC_OP_TRAIN: begin
            c.dummy = {1'b0, dcfg} + `OFC_TRAIN_EXTRA;
            c.rd = 1'b1;
         end
         `OFC_OP_DISC: begin
            c.alen = octal ? 3'd4 : 3'd3;
            c.dummy = `OFC_DISC_DUMMY;
            c.rd = 1'b1;
         end
         `OFC_OP_ID0, `OFC_OP_ID1: begin
            c.dummy = oct_d;
            c.rd = 1'b1;
         end
         `OFC_OP_RSTEN, `OFC_OP_RSTMEM: c.ok = 1'b1;
         default: c.ok = 1'b0;
      endcase
      return c;
   endfunction

   // link edges spent on a number of bytes
   function automatic logic [15:0] byte_ticks(input logic octal, input logic [7:0] n);
      return octal ? {8'h00, n} : {4'h0, n, 4'h0};
   endfunction

   // ****************************************
   // phase sequencing
   // ****************************************
   function automatic ofc_pkg::ofc_st_t enter(input ofc_pkg::ofc_st_t x, input ofc_pkg::ofc_state_t ph);
      if (ph == ofc_pkg::ST_ADDR && x.alen == 3'd0) begin
         ph = ofc_pkg::ST_DUMMY;
      end
      if (ph == ofc_pkg::ST_DUMMY && x.dummy == 6'd0) begin
         ph = ofc_pkg::ST_DATA;
      end
      if (ph == ofc_pkg::ST_DATA && !x.is_rd && !x.is_wr) begin
         ph = ofc_pkg::ST_DESEL;
      end
      x.state = ph;
      case (ph)
         ofc_pkg::ST_ADDR: begin
            x.ticks = byte_ticks(x.octal, {5'h00, x.alen});
            x.sh = (x.alen == 3'd4) ? {x.addr, 32'h0000_0000} : {x.addr[23:0], 40'h00_0000_0000};
         end
         ofc_pkg::ST_DUMMY: x.ticks = {9'h000, x.dummy, 1'b0};
         ofc_pkg::ST_DATA: begin
            x.ticks = byte_ticks(x.octal, x.dlen);
            x.sh = {x.wdata, 56'h00_0000_0000_0000};
            x.bcnt = 3'd0;
         end
         ofc_pkg::ST_DESEL: begin
            x.sel_n = 1'b1;
            x.wait_cnt = 16'h0000;
         end
         default: x.sel_n = x.sel_n;
      endcase
      return x;
   endfunction

   function automatic ofc_pkg::ofc_st_t load_cmd(input ofc_pkg::ofc_st_t x, input logic [7:0] op,
                                                 input logic [7:0] dlen);
      ofc_pkg::ofc_cmd_t c;
      c = cmd_info(op, x.octal, x.four, x.dcfg);
      x.op = op;
      x.done = 1'b0;
      if (!c.ok) begin
         x.err = 1'b1;
         x.done = 1'b1;
         x.busy = 1'b0;
         x.seq = 2'd0;
         x.state = ofc_pkg::ST_IDLE;
      end else begin
         x.alen = c.alen;
         x.dummy = c.dummy;
         x.is_rd = c.rd;
         x.is_wr = c.wr;
         x.dlen = c.wr ? 8'h01 : dlen;
         x.busy = 1'b1;
         x.sel_n = 1'b0;
         x.state = ofc_pkg::ST_CMD;
         x.ticks = x.octal ? 16'h0002 : 16'h0010;
         x.sh = {op, x.octal ? ~op : 8'h00, 48'h0000_0000_0000};
      end
      return x;
   endfunction

   function automatic logic [31:0] reg_read(input ofc_pkg::ofc_st_t x, input logic [7:0] a);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (a)
         `OFC_OFF_CTRL: v = {24'h00_0000, x.op};
         `OFC_OFF_CFG: v = {19'h0_0000, x.dcfg, 7'h00, x.octal};
         `OFC_OFF_ADDR: v = x.addr;
         `OFC_OFF_WDATA: v = {24'h00_0000, x.wdata};
         `OFC_OFF_RLEN: v = {24'h00_0000, x.rlen};
         `OFC_OFF_STATUS: v = {26'h000_0000, x.rst_done, x.dpd, x.four, x.err, x.done, x.busy};
         `OFC_OFF_RDLO: v = x.rd[31:0];
         `OFC_OFF_RDHI: v = x.rd[63:32];
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   function automatic logic reg_hit(input logic [7:0] a);
      return a[1:0] == 2'b00 && a <= `OFC_OFF_RDHI;
   endfunction

   ofc_sclk_gen #(.HALF(SCK_HALF)) u_sck (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .sck(sck),
      .tick(tick),
      .rise(rise)
   );

   assign run = s_r.state == ofc_pkg::ST_CMD || s_r.state == ofc_pkg::ST_ADDR ||
                s_r.state == ofc_pkg::ST_DUMMY || s_r.state == ofc_pkg::ST_DATA;
   assign acc_wr = psel && penable && pwrite;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.sync1 = io_lines_in;
      s_nxt.sync2 = s_r.sync1;
      // apb: data staged in setup, taken in access
      if (psel && !penable) begin
         s_nxt.prdata = pwrite ? 32'h0000_0000 : reg_read(s_r, paddr);
         s_nxt.pslverr = ~reg_hit(paddr);
      end
      if (acc_wr) begin
         case (paddr)
            `OFC_OFF_CFG: begin
               s_nxt.octal = pwdata[`OFC_CFG_OCTAL];
               s_nxt.dcfg = pwdata[`OFC_CFG_DCFG_LO +: 5];
            end
            `OFC_OFF_ADDR: s_nxt.addr = pwdata;
            `OFC_OFF_WDATA: s_nxt.wdata = pwdata[7:0];
            `OFC_OFF_RLEN: s_nxt.rlen = pwdata[7:0];
            `OFC_OFF_STATUS: s_nxt.err = s_r.err & ~pwdata[`OFC_ST_ERR];
            default: s_nxt.op = s_r.op;
         endcase
      end
      // link engine
      case (s_r.state)
         ofc_pkg::ST_IDLE: begin
            if (acc_wr && paddr == `OFC_OFF_CTRL) begin
               if (pwdata[`OFC_CTRL_SRST]) begin
                  s_nxt = load_cmd(s_nxt, `OFC_OP_RSTEN, 8'h01);
                  s_nxt.seq = 2'd1;
                  s_nxt.rst_done = 1'b0;
               end else if (pwdata[`OFC_CTRL_START]) begin
                  s_nxt = load_cmd(s_nxt, pwdata[7:0], s_r.rlen);
               end
            end
         end
         ofc_pkg::ST_DESEL: begin
            s_nxt.wait_cnt = s_r.wait_cnt + 16'h0001;
            if (s_r.wait_cnt >= 16'(DESEL_CYC - 1)) begin
               s_nxt.state = ofc_pkg::ST_IDLE;
               case (s_r.op)
                  `OFC_OP_EN4B: s_nxt.four = 1'b1;
                  `OFC_OP_EX4B: s_nxt.four = 1'b0;
                  `OFC_OP_DPD: s_nxt.dpd = 1'b1;
                  `OFC_OP_RDPD: s_nxt.dpd = 1'b0;
                  default: s_nxt.dpd = s_r.dpd;
               endcase
               case (s_r.seq)
                  2'd1: begin
                     s_nxt = load_cmd(s_nxt, `OFC_OP_RSTMEM, 8'h01);
                     s_nxt.seq = 2'd2;
                  end
                  2'd2: begin
                     s_nxt.four = `OFC_FOUR_RST;
                     s_nxt.dpd = 1'b0;
                     s_nxt = load_cmd(s_nxt, `OFC_OP_RDFLAG, 8'h01);
                     s_nxt.seq = 2'd3;
                  end
                  2'd3: begin
                     if (s_r.rd[63]) begin
                        s_nxt.rst_done = 1'b1;
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                        s_nxt.seq = 2'd0;
                     end else begin
                        s_nxt = load_cmd(s_nxt, `OFC_OP_RDFLAG, 8'h01);
                     end
                  end
                  default: begin
                     s_nxt.busy = 1'b0;
                     s_nxt.done = 1'b1;
                  end
               endcase
            end
         end
         default: begin
            if (tick) begin
               if (s_r.state == ofc_pkg::ST_DATA && s_r.is_rd) begin
                  if (s_r.octal) begin
                     s_nxt.rd = {s_r.sync2, s_r.rd[63:8]};
                  end else if (rise) begin
                     s_nxt.bsh = {s_r.bsh[6:0], s_r.sync2[1]};
                     s_nxt.bcnt = s_r.bcnt + 3'd1;
                     if (s_r.bcnt == 3'd7) begin
                        s_nxt.rd = {s_r.bsh[6:0], s_r.sync2[1], s_r.rd[63:8]};
                     end
                  end
               end else if (s_r.octal) begin
                  s_nxt.sh = {s_r.sh[55:0], 8'h00};
               end else if (!rise) begin
                  s_nxt.sh = {s_r.sh[62:0], 1'b0};
               end
               s_nxt.ticks = s_r.ticks - 16'h0001;
               if (s_r.ticks == 16'h0001) begin
                  case (s_r.state)
                     ofc_pkg::ST_CMD: s_nxt = enter(s_nxt, ofc_pkg::ST_ADDR);
                     ofc_pkg::ST_ADDR: s_nxt = enter(s_nxt, ofc_pkg::ST_DUMMY);
                     ofc_pkg::ST_DUMMY: s_nxt = enter(s_nxt, ofc_pkg::ST_DATA);
                     default: s_nxt = enter(s_nxt, ofc_pkg::ST_DESEL);
                  endcase
               end
            end
         end
      endcase
      // pin drive follows the phase being entered
      if (s_nxt.state == ofc_pkg::ST_CMD || s_nxt.state == ofc_pkg::ST_ADDR ||
          (s_nxt.state == ofc_pkg::ST_DATA && s_nxt.is_wr)) begin
         s_nxt.io_oe_n = s_nxt.octal ? 8'h00 : 8'hfe;
      end else begin
         s_nxt.io_oe_n = 8'hff;
      end
      s_nxt.io_out = s_nxt.octal ? s_nxt.sh[63:56] : {7'h00, s_nxt.sh[63]};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pslverr = psel && penable && s_r.pslverr;
   assign pready = psel && penable;
   assign sel_n = s_r.sel_n;
   assign io_lines_out = s_r.io_out;
   assign io_lines_oe_n = s_r.io_oe_n;

endmodule

//--- src/ofc_pkg.sv
// Purpose: types of the flash command controller
// Assumes: nothing
// Notes: constants live in ofc_cfg.svh
package ofc_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD = 3'b001,
      ST_ADDR = 3'b010,
      ST_DUMMY = 3'b011,
      ST_DATA = 3'b100,
      ST_DESEL = 3'b101
   } ofc_state_t;

   typedef struct packed {
      logic ok;
      logic [2:0] alen;
      logic [5:0] dummy;
      logic rd;
      logic wr;
   } ofc_cmd_t;

   typedef struct packed {
      ofc_state_t state;
      logic [1:0] seq;
      logic [7:0] op;
      logic octal;
      logic [4:0] dcfg;
      logic [31:0] addr;
      logic [7:0] wdata;
      logic [7:0] rlen;
      logic [7:0] dlen;
      logic busy;
      logic done;
      logic err;
      logic four;
      logic dpd;
      logic rst_done;
      logic [63:0] sh;
      logic [63:0] rd;
      logic [7:0] bsh;
      logic [2:0] bcnt;
      logic [15:0] ticks;
      logic [2:0] alen;
      logic [5:0] dummy;
      logic is_rd;
      logic is_wr;
      logic sel_n;
      logic [7:0] io_out;
      logic [7:0] io_oe_n;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [15:0] wait_cnt;
      logic [31:0] prdata;
      logic pslverr;
   } ofc_st_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic sck;
   } ofc_sck_st_t;

endpackage

//--- src/ofc_sclk_gen.sv
// Purpose: serial clock divider for the flash link
// Assumes: run held high for the whole selection
// Notes: sck idles low; tick marks every edge the divider makes
`timescale 1ns/1ps
module ofc_sclk_gen #(
   parameter int HALF = 4
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic run,
   // link clock
   output logic sck,
   output logic tick,
   output logic rise
);

   ofc_pkg::ofc_sck_st_t s_r;
   ofc_pkg::ofc_sck_st_t s_nxt;

   // ****************************************
   // divider
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      tick = 1'b0;
      rise = 1'b0;
      if (!run) begin
         s_nxt.cnt = 16'h0000;
         s_nxt.sck = 1'b0;
      end else if (s_r.cnt == 16'(HALF - 1)) begin
         s_nxt.cnt = 16'h0000;
         s_nxt.sck = ~s_r.sck;
         tick = 1'b1;
         rise = ~s_r.sck;
      end else begin
         s_nxt.cnt = s_r.cnt + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sck = s_r.sck;

endmodule
